// ===== common/tpsr_pkg.sv
// types shared by the preprocessor status bank
`default_nettype none
package tpsr_pkg;
   typedef enum logic [1:0] {
      TPSR_ZONE_OFF = 2'b00,
      TPSR_ZONE_BELOW = 2'b01,
      TPSR_ZONE_BETWEEN = 2'b10,
      TPSR_ZONE_ABOVE = 2'b11
   } tpsr_zone_t;
endpackage
`default_nettype wire

// ===== common/tpsr_regs.svh
// register indices, field positions, reset values of the preprocessor status bank
`ifndef TPSR_REGS_SVH
`define TPSR_REGS_SVH

`define TPSR_REG_W 16
`define TPSR_NUM_RESULTS 7
`define TPSR_IDX_AUX 4'h4
`define TPSR_IDX_TEMP1 4'h5
`define TPSR_IDX_TEMP2 4'h6
`define TPSR_IDX_STATUS 4'h7
`define TPSR_IDX_CONFIG 4'he
`define TPSR_IDX_FUNC 4'hf

`define TPSR_CONFIG_RST 16'h0000
`define TPSR_CONFIG_WMASK 16'hffdf
`define TPSR_FUNC_RST 16'h0000
`define TPSR_BIAS_STATUS_RST 1'b1

`define TPSR_CFG_SEL_HI 15
`define TPSR_CFG_SEL_LO 14
`define TPSR_CFG_FILT_HI 13
`define TPSR_CFG_FILT_LO 10
`define TPSR_CFG_TZ_HI 9
`define TPSR_CFG_TZ_LO 8
`define TPSR_CFG_AZ_HI 7
`define TPSR_CFG_AZ_LO 6
`define TPSR_CFG_FEN_HI 4
`define TPSR_CFG_FEN_LO 0

`define TPSR_ST_DAV_HI 15
`define TPSR_ST_DAV_LO 9
`define TPSR_ST_RESET_FLAG 7
`define TPSR_ST_X_LINK 6
`define TPSR_ST_Y_LINK 5
`define TPSR_ST_Y_SHORT 3
`define TPSR_ST_BIAS 2

`define TPSR_FN_DRV_XX 13
`define TPSR_FN_DRV_YY 14
`define TPSR_FN_DRV_YX 15
`define TPSR_FN_RUN_HI 12
`define TPSR_FN_LAST_CODE 4'hc

`define TPSR_GROUP_TOUCH 7'h0f
`define TPSR_GROUP_AUX 7'h10
`define TPSR_GROUP_TEMP 7'h60

`endif

// ===== design/tpsr_status_bank.sv
// preprocessor config, function status and device status registers with link crossing
`default_nettype none
`include "tpsr_regs.svh"

module tpsr_status_bank #(
   parameter int RESULT_W = 12,
   parameter logic [1:0] VERSION = 2'b10 // arbitrary version value
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic link_clk_i,
   input wire logic link_req_i,
   input wire logic link_wr_i,
   input wire logic [3:0] link_addr_i,
   input wire logic [15:0] link_wdata_i,
   output logic link_busy_o,
   output logic link_done_o,
   output logic [15:0] link_rdata_o,
   input wire logic soft_reset_i,
   input wire logic touch_irq_n_i,
   input wire logic result_valid_i,
   input wire logic [3:0] result_sel_i,
   input wire logic [RESULT_W-1:0] result_data_i,
   input wire logic [RESULT_W-1:0] aux_high_i,
   input wire logic [RESULT_W-1:0] aux_low_i,
   input wire logic [RESULT_W-1:0] temp_high_i,
   input wire logic [RESULT_W-1:0] temp_low_i,
   input wire logic filter_busy_i,
   input wire logic [6:0] filter_busy_sel_i,
   input wire logic function_start_i,
   input wire logic [3:0] function_code_i,
   input wire logic function_done_i,
   input wire logic done_no_touch_i,
   input wire logic stop_bit_i,
   input wire logic pen_start_mode_i,
   input wire logic x_plus_on_i,
   input wire logic x_minus_on_i,
   input wire logic y_plus_on_i,
   input wire logic y_minus_on_i,
   input wire logic x_link_ok_i,
   input wire logic y_link_ok_i,
   input wire logic y_no_short_i,
   input wire logic bias_down_ctl_i,
   input wire logic conv_active_i,
   input wire logic set_active_i,
   output logic irq_data_pin_o,
   output logic busy_o,
   output logic filter_bypass_o,
   output logic [1:0] filter_depth_o,
   output logic [1:0] filter_window_o,
   output logic [4:0] filter_enable_o,
   output logic bias_on_o
);

   if (RESULT_W < 8 || RESULT_W > 15) begin : g_width_check
      $error("tpsr_status_bank: RESULT_W must lie in 8..15");
   end

   // link domain: request capture and answer pickup
   logic req_tgl_reg;
   logic req_wr_reg;
   logic [3:0] req_addr_reg;
   logic [15:0] req_wdata_reg;
   logic pending_reg;
   logic ack_s1_reg;
   logic ack_s2_reg;
   logic ack_s3_reg;
   logic ack_edge;

   // system domain
   logic req_s1_reg;
   logic req_s2_reg;
   logic req_s3_reg;
   logic req_edge;
   logic acc_wr;
   logic acc_rd;
   logic ack_tgl_reg;
   logic [15:0] sys_rdata_reg;

   logic [15:0] cfg_reg;
   logic [15:0] func_reg;
   logic [RESULT_W-1:0] result_mem [0:`TPSR_NUM_RESULTS-1];
   logic [6:0] unread_reg;
   logic [6:0] dav_reg;
   logic reset_flag_reg;
   logic bias_down_status_reg;
   logic [6:0] store_vec;
   logic [6:0] read_vec;
   logic [6:0] dav_shown;
   logic accept;
   logic [15:0] status_word;
   logic [15:0] read_word;
   logic func_running;
   logic keep_pen_scan;

   function automatic logic zone_hit(input tpsr_pkg::tpsr_zone_t mode,
                                     input logic [RESULT_W-1:0] val,
                                     input logic [RESULT_W-1:0] hi,
                                     input logic [RESULT_W-1:0] lo);
      logic hit;
      hit = 1'b1;
      unique case (mode)
         tpsr_pkg::TPSR_ZONE_OFF: hit = 1'b1;
         tpsr_pkg::TPSR_ZONE_BELOW: hit = (val < lo);
         tpsr_pkg::TPSR_ZONE_BETWEEN: hit = (val >= lo) && (val <= hi);
         tpsr_pkg::TPSR_ZONE_ABOVE: hit = (val > hi);
      endcase
      return hit;
   endfunction

   function automatic logic [6:0] group_of(input int idx);
      logic [6:0] g;
      g = `TPSR_GROUP_TEMP;
      if (idx < 4) begin
         g = `TPSR_GROUP_TOUCH;
      end else if (idx == 4) begin
         g = `TPSR_GROUP_AUX;
      end
      return g;
   endfunction

   // ---------------- link domain ----------------
   always_ff @(posedge link_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ack_s1_reg <= 1'b0;
         ack_s2_reg <= 1'b0;
         ack_s3_reg <= 1'b0;
      end else begin
         ack_s1_reg <= ack_tgl_reg;
         ack_s2_reg <= ack_s1_reg;
         ack_s3_reg <= ack_s2_reg;
      end
   end

   assign ack_edge = ack_s2_reg ^ ack_s3_reg;

   // request fields stay frozen while pending, so the system side reads them safely
   always_ff @(posedge link_clk_i or posedge reset_i) begin
      if (reset_i) begin
         req_tgl_reg <= 1'b0;
         req_wr_reg <= 1'b0;
         req_addr_reg <= 4'h0;
         req_wdata_reg <= 16'h0000;
         pending_reg <= 1'b0;
      end else if (link_req_i && !pending_reg) begin
         req_tgl_reg <= ~req_tgl_reg;
         req_wr_reg <= link_wr_i;
         req_addr_reg <= link_addr_i;
         req_wdata_reg <= link_wdata_i;
         pending_reg <= 1'b1;
      end else if (ack_edge) begin
         pending_reg <= 1'b0;
      end
   end

   always_ff @(posedge link_clk_i or posedge reset_i) begin
      if (reset_i) begin
         link_done_o <= 1'b0;
         link_rdata_o <= 16'h0000;
         link_busy_o <= 1'b0;
      end else begin
         link_done_o <= ack_edge;
         link_busy_o <= (pending_reg && !ack_edge) || (link_req_i && !pending_reg);
         if (ack_edge) begin
            link_rdata_o <= sys_rdata_reg;
         end
      end
   end

   // ---------------- system domain ----------------
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         req_s1_reg <= 1'b0;
         req_s2_reg <= 1'b0;
         req_s3_reg <= 1'b0;
      end else begin
         req_s1_reg <= req_tgl_reg;
         req_s2_reg <= req_s1_reg;
         req_s3_reg <= req_s2_reg;
      end
   end

   assign req_edge = req_s2_reg ^ req_s3_reg;
   assign acc_wr = req_edge && req_wr_reg;
   assign acc_rd = req_edge && !req_wr_reg;

   // filter first, then zone: result_data_i is already the filtered value
   always_comb begin
      accept = 1'b1;
      if (result_sel_i == `TPSR_IDX_AUX) begin
         accept = zone_hit(tpsr_pkg::tpsr_zone_t'(cfg_reg[`TPSR_CFG_AZ_HI:`TPSR_CFG_AZ_LO]),
                           result_data_i, aux_high_i, aux_low_i);
      end else if (result_sel_i == `TPSR_IDX_TEMP1 || result_sel_i == `TPSR_IDX_TEMP2) begin
         accept = zone_hit(tpsr_pkg::tpsr_zone_t'(cfg_reg[`TPSR_CFG_TZ_HI:`TPSR_CFG_TZ_LO]),
                           result_data_i, temp_high_i, temp_low_i);
      end
   end

   always_comb begin
      for (int i = 0; i < `TPSR_NUM_RESULTS; i++) begin
         store_vec[i] = result_valid_i && accept && (result_sel_i == 4'(i));
         read_vec[i] = acc_rd && (req_addr_reg == 4'(i));
      end
   end

   // software reset loads defaults; hardware reset wins through the async path
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cfg_reg <= `TPSR_CONFIG_RST;
      end else if (soft_reset_i) begin
         cfg_reg <= `TPSR_CONFIG_RST;
      end else if (acc_wr && req_addr_reg == `TPSR_IDX_CONFIG) begin
         cfg_reg <= req_wdata_reg & `TPSR_CONFIG_WMASK;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         for (int i = 0; i < `TPSR_NUM_RESULTS; i++) begin
            result_mem[i] <= '0;
         end
      end else if (soft_reset_i) begin
         for (int i = 0; i < `TPSR_NUM_RESULTS; i++) begin
            result_mem[i] <= '0;
         end
      end else begin
         for (int i = 0; i < `TPSR_NUM_RESULTS; i++) begin
            if (store_vec[i]) begin
               result_mem[i] <= result_data_i;
            end
         end
      end
   end

   // a new result in the same cycle as its read stays unread
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         unread_reg <= 7'h00;
      end else if (soft_reset_i) begin
         unread_reg <= 7'h00;
      end else begin
         unread_reg <= (unread_reg & ~read_vec) | store_vec;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         dav_reg <= 7'h00;
      end else if (soft_reset_i) begin
         dav_reg <= 7'h00;
      end else begin
         for (int i = 0; i < `TPSR_NUM_RESULTS; i++) begin
            if (store_vec[i]) begin
               dav_reg[i] <= 1'b1;
            end else if ((unread_reg & ~read_vec & group_of(i)) == 7'h00) begin
               dav_reg[i] <= 1'b0;
            end
         end
      end
   end

   assign dav_shown = dav_reg & ~(filter_busy_i ? filter_busy_sel_i : 7'h00);

   assign func_running = |func_reg[`TPSR_FN_RUN_HI:0];
   assign keep_pen_scan = pen_start_mode_i && done_no_touch_i &&
                          (func_reg[1:0] != 2'b00);

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         func_reg <= `TPSR_FUNC_RST;
      end else if (soft_reset_i || stop_bit_i) begin
         func_reg <= `TPSR_FUNC_RST;
      end else if (function_done_i) begin
         func_reg <= `TPSR_FUNC_RST;
         if (keep_pen_scan) begin
            func_reg[1:0] <= func_reg[1:0];
         end
      end else begin
         if (function_start_i && function_code_i <= `TPSR_FN_LAST_CODE) begin
            func_reg[`TPSR_FN_RUN_HI:0] <= 13'h0001 << function_code_i;
         end
         func_reg[`TPSR_FN_DRV_XX] <= x_plus_on_i && x_minus_on_i;
         func_reg[`TPSR_FN_DRV_YY] <= y_plus_on_i && y_minus_on_i;
         func_reg[`TPSR_FN_DRV_YX] <= y_plus_on_i && x_minus_on_i;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         reset_flag_reg <= 1'b0;
      end else if (soft_reset_i) begin
         reset_flag_reg <= 1'b0;
      end else if (acc_rd && req_addr_reg == `TPSR_IDX_STATUS) begin
         reset_flag_reg <= 1'b1;
      end
   end

   // the status copy only moves while the internal clock would be running
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         bias_down_status_reg <= `TPSR_BIAS_STATUS_RST;
      end else if (soft_reset_i) begin
         bias_down_status_reg <= `TPSR_BIAS_STATUS_RST;
      end else if (!touch_irq_n_i || func_running) begin
         bias_down_status_reg <= bias_down_ctl_i;
      end
   end

   always_comb begin
      status_word = 16'h0000;
      status_word[`TPSR_ST_DAV_HI:`TPSR_ST_DAV_LO] = {dav_shown[0], dav_shown[1], dav_shown[2],
         dav_shown[3], dav_shown[4], dav_shown[5], dav_shown[6]};
      status_word[`TPSR_ST_RESET_FLAG] = reset_flag_reg;
      status_word[`TPSR_ST_X_LINK] = x_link_ok_i;
      status_word[`TPSR_ST_Y_LINK] = y_link_ok_i;
      status_word[`TPSR_ST_Y_SHORT] = y_no_short_i;
      status_word[`TPSR_ST_BIAS] = bias_down_status_reg;
      status_word[1:0] = VERSION;
   end

   always_comb begin
      read_word = 16'h0000;
      if (req_addr_reg < `TPSR_IDX_STATUS) begin
         read_word = {{(16-RESULT_W){1'b0}}, result_mem[req_addr_reg[2:0]]};
      end else if (req_addr_reg == `TPSR_IDX_STATUS) begin
         read_word = status_word;
      end else if (req_addr_reg == `TPSR_IDX_CONFIG) begin
         read_word = cfg_reg;
      end else if (req_addr_reg == `TPSR_IDX_FUNC) begin
         read_word = func_reg;
      end
   end

   // answer word is held until the next request, so the link samples it stable
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         sys_rdata_reg <= 16'h0000;
         ack_tgl_reg <= 1'b0;
      end else if (req_edge) begin
         sys_rdata_reg <= acc_rd ? read_word : 16'h0000;
         ack_tgl_reg <= ~ack_tgl_reg;
      end
   end

   // ---------------- outputs toward pin and converter ----------------
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         irq_data_pin_o <= 1'b1;
      end else if (cfg_reg[`TPSR_CFG_SEL_LO]) begin
         irq_data_pin_o <= ~(|dav_shown);
      end else if (cfg_reg[`TPSR_CFG_SEL_HI]) begin
         irq_data_pin_o <= touch_irq_n_i;
      end else begin
         irq_data_pin_o <= touch_irq_n_i && !(|dav_shown);
      end
   end
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         busy_o <= 1'b0;
         filter_bypass_o <= 1'b1;
         bias_on_o <= 1'b0;
      end else begin
         busy_o <= filter_busy_i || func_running;
         filter_bypass_o <= (cfg_reg[`TPSR_CFG_FILT_HI:`TPSR_CFG_FILT_LO] == 4'h0);
         bias_on_o <= conv_active_i || (set_active_i && !bias_down_status_reg);
      end
   end
   // config fields drive the filter engine straight from the register
   assign filter_depth_o = cfg_reg[13:12];
   assign filter_window_o = cfg_reg[11:10];
   assign filter_enable_o = cfg_reg[`TPSR_CFG_FEN_HI:`TPSR_CFG_FEN_LO];
endmodule // tpsr_status_bank
`default_nettype wire

// ===== sim/tpsr_host_model.sv
// host processor model driving the register link
`default_nettype none
module tpsr_host_model (
   input wire logic link_clk_i,
   output logic req_o,
   output logic wr_o,
   output logic [3:0] addr_o,
   output logic [15:0] wdata_o,
   input wire logic busy_i,
   input wire logic done_i,
   input wire logic [15:0] rdata_i
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {req_o, wr_o, addr_o, wdata_o} = '0;
   task automatic access(input logic w, input logic [3:0] a, input logic [15:0] d,
         output logic [15:0] q, output logic ok);
      ok = 1'b0;
      q = 16'h0000;
      @(posedge link_clk_i);
      {req_o, wr_o, addr_o, wdata_o} <= {1'b1, w, a, d};
      for (int n = 0; n < 40 && !ok; n++) begin
         @(posedge link_clk_i);
         // drop request once taken, else it would be taken again after the answer
         if (busy_i === 1'b1) req_o <= 1'b0;
         if (done_i === 1'b1) begin
            ok = 1'b1;
            q = rdata_i;
         end
      end
      // released lines show the inverse so a stale value cannot pass
      {wr_o, addr_o, wdata_o} <= ~{w, a, d};
   endtask
endmodule // tpsr_host_model
`default_nettype wire

// ===== sim/tpsr_status_bank_monitor.sv
// port assertions for the preprocessor status bank
`default_nettype none
module tpsr_status_bank_mon (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic link_clk_i,
   input wire logic link_req_i,
   input wire logic link_busy_o,
   input wire logic link_done_o,
   input wire logic soft_reset_i,
   input wire logic touch_irq_n_i,
   input wire logic filter_busy_i,
   input wire logic bias_down_ctl_i,
   input wire logic conv_active_i,
   input wire logic set_active_i,
   input wire logic busy_o,
   input wire logic filter_bypass_o,
   input wire logic [1:0] filter_depth_o,
   input wire logic [1:0] filter_window_o,
   input wire logic bias_on_o
);
   AST_BYPASS: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      filter_bypass_o == $past(filter_depth_o == 2'h0 && filter_window_o == 2'h0))
      else $error("bypass flag does not follow filter fields");
   AST_FILT_BUSY: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      filter_busy_i && !soft_reset_i |=> busy_o)
      else $error("busy low while filtering");
   AST_BIAS_CONV: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      conv_active_i |=> bias_on_o)
      else $error("bias off during conversion");
   AST_BIAS_IDLE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      !conv_active_i && !set_active_i |=> !bias_on_o)
      else $error("bias on between sets");
   AST_BIAS_KEPT: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (!touch_irq_n_i && !soft_reset_i && !bias_down_ctl_i) [*2] ##0 set_active_i
      |=> bias_on_o)
      else $error("bias dropped inside a set");
   AST_BIAS_CUT: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (!touch_irq_n_i && !soft_reset_i && bias_down_ctl_i) [*2] ##0 !conv_active_i
      |=> !bias_on_o)
      else $error("bias kept while powered down");
   AST_LINK_PULSE: assert property (@(posedge link_clk_i) disable iff (reset_i)
      link_done_o |=> !link_done_o)
      else $error("answer pulse longer than one cycle");
   AST_LINK_TAKE: assert property (@(posedge link_clk_i) disable iff (reset_i)
      link_req_i && !link_busy_o && !link_done_o |=> link_busy_o)
      else $error("request not taken");
   AST_LINK_ANSWER: assert property (@(posedge link_clk_i) disable iff (reset_i)
      $rose(link_busy_o) |-> ##[1:16] link_done_o)
      else $error("no answer to request");
   AST_LINK_CAUSE: assert property (@(posedge link_clk_i) disable iff (reset_i)
      link_done_o |-> $past(link_busy_o))
      else $error("answer without request");
   cover property (@(posedge link_clk_i) disable iff (reset_i) link_done_o);
   cover property (@(posedge sys_clk_i) disable iff (reset_i) filter_busy_i ##1 busy_o);
   cover property (@(posedge sys_clk_i) disable iff (reset_i) bias_on_o && !conv_active_i);
endmodule // tpsr_status_bank_mon
bind tpsr_status_bank tpsr_status_bank_mon mon (.sys_clk_i, .reset_i, .link_clk_i,
   .link_req_i, .link_busy_o, .link_done_o, .soft_reset_i, .touch_irq_n_i, .filter_busy_i,
   .bias_down_ctl_i, .conv_active_i, .set_active_i, .busy_o, .filter_bypass_o,
   .filter_depth_o, .filter_window_o, .bias_on_o);
`default_nettype wire

// ===== sim/tpsr_status_bank_test.sv
// self-checking bench for the preprocessor status bank
`default_nettype none
`include "tpsr_regs.svh"
module tpsr_status_bank_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [1:0] VER = 2'b01; // arbitrary version value
   localparam logic [3:0] DRV [4] = '{4'h0, 4'h3, 4'hc, 4'h9};
   localparam logic [15:0] DRB [4] = '{16'h0000, 16'h2000, 16'h4000, 16'h8000};
   logic sys_clk_i, reset_i, link_clk_i, link_req_i, link_wr_i, link_busy_o, link_done_o;
   logic soft_reset_i, touch_irq_n_i, result_valid_i, filter_busy_i, function_start_i;
   logic function_done_i, done_no_touch_i, stop_bit_i, pen_start_mode_i, x_plus_on_i;
   logic x_minus_on_i, y_plus_on_i, y_minus_on_i, x_link_ok_i, y_link_ok_i, y_no_short_i;
   logic bias_down_ctl_i, conv_active_i, set_active_i, irq_data_pin_o, busy_o;
   logic filter_bypass_o, bias_on_o;
   logic [3:0] link_addr_i, result_sel_i, function_code_i;
   logic [15:0] link_wdata_i, link_rdata_o;
   logic [11:0] result_data_i, aux_high_i, aux_low_i, temp_high_i, temp_low_i;
   logic [6:0] filter_busy_sel_i;
   logic [1:0] filter_depth_o, filter_window_o;
   logic [4:0] filter_enable_o;
   int fail_count = 0;
   int n_checks = 0;
   tpsr_status_bank #(.VERSION(VER)) dut (.sys_clk_i, .reset_i, .link_clk_i, .link_req_i,
      .link_wr_i, .link_addr_i, .link_wdata_i, .link_busy_o, .link_done_o, .link_rdata_o,
      .soft_reset_i, .touch_irq_n_i, .result_valid_i, .result_sel_i, .result_data_i,
      .aux_high_i, .aux_low_i, .temp_high_i, .temp_low_i, .filter_busy_i, .filter_busy_sel_i,
      .function_start_i, .function_code_i, .function_done_i, .done_no_touch_i, .stop_bit_i,
      .pen_start_mode_i, .x_plus_on_i, .x_minus_on_i, .y_plus_on_i, .y_minus_on_i,
      .x_link_ok_i, .y_link_ok_i, .y_no_short_i, .bias_down_ctl_i, .conv_active_i,
      .set_active_i, .irq_data_pin_o, .busy_o, .filter_bypass_o, .filter_depth_o,
      .filter_window_o, .filter_enable_o, .bias_on_o);
   tpsr_host_model host (.link_clk_i, .req_o(link_req_i), .wr_o(link_wr_i),
      .addr_o(link_addr_i), .wdata_o(link_wdata_i), .busy_i(link_busy_o),
      .done_i(link_done_o), .rdata_i(link_rdata_o));
   initial begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      link_clk_i = 1'b0;
      #3;
      forever #16 link_clk_i = ~link_clk_i;
   end
   task automatic complete_run();
      if (fail_count == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d,
         output logic [15:0] q);
      logic ok;
      host.access(w, a, d, q, ok);
      if (!ok) begin
         fail_count++;
         $display("[ERR] %0t no link answer", $time);
         complete_run();
      end
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m = 16'hffff);
      logic [15:0] q;
      acc(1'b0, a, 16'h0000, q);
      chk(q & m, e);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      logic [15:0] q;
      acc(1'b1, a, d, q);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   task automatic push(input logic [3:0] s, input logic [11:0] d);
      @(posedge sys_clk_i);
      {result_valid_i, result_sel_i, result_data_i} <= {1'b1, s, d};
      @(posedge sys_clk_i);
      result_valid_i <= 1'b0;
   endtask
   function automatic logic [15:0] outs();
      return {6'h00, filter_bypass_o, filter_depth_o, filter_window_o, filter_enable_o};
   endfunction
   task automatic t_reset();
      rd(`TPSR_IDX_STATUS, 16'h004c | 16'(VER));
      rd(`TPSR_IDX_STATUS, 16'h00cc | 16'(VER));
      rd(`TPSR_IDX_FUNC, 16'h0000);
      rd(4'h9, 16'h0000);
      @(posedge sys_clk_i);
      {x_link_ok_i, y_link_ok_i, y_no_short_i} <= 3'b010;
      rd(`TPSR_IDX_STATUS, 16'h00a4 | 16'(VER));
   endtask
   task automatic t_config();
      rd(`TPSR_IDX_CONFIG, 16'h0000);
      wr(`TPSR_IDX_CONFIG, 16'hffff);
      rd(`TPSR_IDX_CONFIG, 16'hffdf);
      chk(outs(), 16'h01ff);
      wr(`TPSR_IDX_CONFIG, 16'h1403);
      rd(`TPSR_IDX_CONFIG, 16'h1403);
      chk(outs(), 16'h00a3);
      wr(`TPSR_IDX_FUNC, 16'hffff);
      rd(`TPSR_IDX_FUNC, 16'h0000);
      wr(`TPSR_IDX_CONFIG, 16'h0000);
      cyc(2);
      chk(outs(), 16'h0200);
   endtask
   task automatic t_busy();
      push(4'h0, 12'h123);
      @(posedge sys_clk_i);
      {filter_busy_i, filter_busy_sel_i} <= {1'b1, 7'h01};
      cyc(2);
      chk(busy_o, 16'h0001);
      rd(`TPSR_IDX_STATUS, 16'h0000, 16'hfe00);
      @(posedge sys_clk_i);
      filter_busy_i <= 1'b0;
      rd(`TPSR_IDX_STATUS, 16'h8000, 16'hfe00);
      rd(4'h0, 16'h0123);
   endtask
   task automatic t_pin();
      logic d;
      for (int k = 0; k < 16; k++) begin
         d = k > 7;
         if (k == 8) begin
            push(4'h0, 12'h5a3);
            push(4'h1, 12'h0a5);
         end
         wr(`TPSR_IDX_CONFIG, {k[1:0], 14'h0000});
         @(posedge sys_clk_i);
         touch_irq_n_i <= k[2];
         cyc(3);
         chk(irq_data_pin_o, k[1:0] == 2'b10 ? k[2] : (k[0] | k[2]) & ~d);
      end
      rd(4'h0, 16'h05a3);
      rd(`TPSR_IDX_STATUS, 16'hc000, 16'hfe00);
      rd(4'h1, 16'h00a5);
      rd(`TPSR_IDX_STATUS, 16'h0000, 16'hfe00);
      wr(`TPSR_IDX_CONFIG, 16'h0000);
      @(posedge sys_clk_i);
      touch_irq_n_i <= 1'b1;
   endtask
   task automatic t_zone();
      logic [11:0] v;
      logic h;
      for (int t = 0; t < 2; t++) begin
         for (int md = 0; md < 4; md++) begin
            for (int j = 0; j < 3; j++) begin
               v = 12'h032 + 12'h064 * 12'(j);
               h = md == 0 || md == j + 1;
               wr(`TPSR_IDX_CONFIG, t == 1 ? 16'(md) << 8 : 16'(md) << 6);
               push(t == 1 ? `TPSR_IDX_TEMP1 : `TPSR_IDX_AUX, v);
               rd(`TPSR_IDX_STATUS, {4'h0, t == 0 && h, t == 1 && h, 10'h000},
                  16'h0c00);
               if (h) rd(t == 1 ? `TPSR_IDX_TEMP1 : `TPSR_IDX_AUX, {4'h0, v});
            end
         end
      end
      push(`TPSR_IDX_TEMP2, 12'h0fa);
      rd(`TPSR_IDX_STATUS, 16'h0200, 16'h0200);
      push(`TPSR_IDX_TEMP2, 12'h032);
      rd(`TPSR_IDX_TEMP2, 16'h00fa);
      rd(`TPSR_IDX_STATUS, 16'h0000, 16'h0200);
   endtask
   task automatic t_func();
      for (int c = 0; c < 16; c++) begin
         @(posedge sys_clk_i);
         {function_start_i, function_code_i} <= {1'b1, 4'(c)};
         {y_plus_on_i, y_minus_on_i, x_plus_on_i, x_minus_on_i} <= DRV[c % 4];
         @(posedge sys_clk_i);
         function_start_i <= 1'b0;
         rd(`TPSR_IDX_FUNC, (c < 13 ? 16'h0001 << c : 16'h0000) | DRB[c % 4]);
         chk(busy_o, 16'(c < 13));
         @(posedge sys_clk_i);
         {y_plus_on_i, y_minus_on_i, x_plus_on_i, x_minus_on_i} <= 4'h0;
         {stop_bit_i, function_done_i} <= c[0] ? 2'b10 : 2'b01;
         @(posedge sys_clk_i);
         {stop_bit_i, function_done_i} <= 2'b00;
         rd(`TPSR_IDX_FUNC, 16'h0000);
      end
      @(posedge sys_clk_i);
      {pen_start_mode_i, function_start_i, function_code_i} <= {2'b11, 4'h1};
      @(posedge sys_clk_i);
      {function_start_i, function_done_i, done_no_touch_i} <= 3'b011;
      @(posedge sys_clk_i);
      {function_done_i, done_no_touch_i, pen_start_mode_i} <= 3'b000;
      rd(`TPSR_IDX_FUNC, 16'h0002);
   endtask
   task automatic t_bias();
      @(posedge sys_clk_i);
      {stop_bit_i, touch_irq_n_i, bias_down_ctl_i, set_active_i} <= 4'b1001;
      cyc(3);
      chk(bias_on_o, 16'h0001);
      rd(`TPSR_IDX_STATUS, 16'h0000, 16'h0004);
      @(posedge sys_clk_i);
      bias_down_ctl_i <= 1'b1;
      cyc(3);
      chk(bias_on_o, 16'h0000);
      {touch_irq_n_i, bias_down_ctl_i, conv_active_i} <= 3'b101;
      cyc(3);
      chk(bias_on_o, 16'h0001);
      rd(`TPSR_IDX_STATUS, 16'h0004, 16'h0004);
      @(posedge sys_clk_i);
      {stop_bit_i, conv_active_i, set_active_i} <= 3'b000;
      wr(`TPSR_IDX_CONFIG, 16'h2c00);
      @(posedge sys_clk_i);
      soft_reset_i <= 1'b1;
      cyc(2);
      soft_reset_i <= 1'b0;
      rd(`TPSR_IDX_CONFIG, 16'h0000);
      rd(`TPSR_IDX_STATUS, 16'h0004, 16'h0084);
   endtask
   initial begin
      {soft_reset_i, result_valid_i, filter_busy_i, function_start_i, function_done_i} = '0;
      {done_no_touch_i, stop_bit_i, pen_start_mode_i, x_plus_on_i, x_minus_on_i} = '0;
      {y_plus_on_i, y_minus_on_i, y_link_ok_i, bias_down_ctl_i, conv_active_i} = '0;
      {set_active_i, result_sel_i, function_code_i, result_data_i, filter_busy_sel_i} = '0;
      {x_link_ok_i, y_no_short_i, touch_irq_n_i, reset_i} = 4'hf;
      {aux_high_i, aux_low_i, temp_high_i, temp_low_i} = {12'h0c8, 12'h064, 12'h0c8, 12'h064};
      // held over link edges too, the slower domain must see reset
      repeat (3) @(posedge link_clk_i);
      @(posedge sys_clk_i);
      reset_i <= 1'b0;
      t_reset();
      t_config();
      t_busy();
      t_pin();
      t_zone();
      t_func();
      t_bias();
      complete_run();
   end
endmodule // tpsr_status_bank_test
`default_nettype wire
